//--- design/spfc_ctrl.sv
// per-port mirror, vlan membership, filter and flow control register bank with forwarding decisions
`timescale 1ns/100ps
// Function
// - ctrl1 bit7 makes the port the mirror destination for monitored packets.
// - ctrl1 bit6 marks all packets received on the port as monitored.
// - ctrl1 bit5 marks all packets transmitted on the port as monitored.
// - ctrl1 bit4 adds the ingress default tag to every packet.
// - ctrl1 bits 2..0 are membership mask: bit2 port3, bit1 port2, bit0 port1.
// - received traffic only goes to ports in the ingress membership mask, except mirror copies.
// - reset mask holds own-port one, other bits from straps.
// - ctrl2 bit6 drops packets whose vlan membership excludes the ingress port.
// - ctrl2 bit5 drops packets whose vid differs from the port default vid.
// - ctrl2 bit4 forces flow control on, else autonegotiation result; reset from strap on ports 1 and 2, zero on port 3.
// - port 3 ignores ctrl2 bit4; global register 6 bit 5 governs it.
// - ctrl2 bit3 enables half-duplex back pressure; reset from strap.
// - ctrl2 bit2 permits transmission; resets to one.
// - ctrl2 bit1 permits reception; resets to one.
// - ctrl2 bit0 stops source address learning; resets to zero.
// - control-one registers decode at 0x11, 0x21, 0x31.
// - control-two registers decode at 0x12, 0x22, 0x32.
// - default vid is the 12-bit value of the default tag registers.
module spfc_ctrl (
    input  wire logic                         i_clock,          // 10 MHz system clock
    input  wire logic                         i_reset,          // synchronous, active high
    input  wire logic [spfc_pkg::ADDR_W-1:0]  i_addr,           // register address
    input  wire logic [spfc_pkg::DATA_W-1:0]  i_wdata,          // register write data
    input  wire logic                         i_wr,             // write strobe
    input  wire logic                         i_rd,             // read strobe
    output logic      [spfc_pkg::DATA_W-1:0]  o_rdata,          // read data, cycle after i_rd
    input  wire logic                         i_strap_p1_member_of_p3,   // strap
    input  wire logic                         i_strap_p1_member_of_p2,   // strap
    input  wire logic                         i_strap_p2_member_of_p3,   // strap
    input  wire logic                         i_strap_p2_member_of_p1,   // strap
    input  wire logic                         i_strap_p3_member_of_p2,   // strap
    input  wire logic                         i_strap_p3_member_of_p1,   // strap
    input  wire logic                         i_strap_first_forced_pause,  // strap port 1
    input  wire logic                         i_strap_second_forced_pause, // strap port 2
    input  wire logic                         i_strap_backpressure_on,     // strap all ports
    input  wire logic [2:0]                   i_an_pause,       // autoneg flow control result per port
    input  wire logic                         i_global_p3_fc,   // global register 6 bit 5
    input  wire logic                         i_pkt_valid,      // forwarding lookup request
    input  wire logic [1:0]                   i_pkt_src,        // ingress port index 0..2
    input  wire logic [2:0]                   i_pkt_dst,        // resolved destination ports
    input  wire logic [11:0]                  i_pkt_vid,        // packet vid
    input  wire logic                         i_pkt_tagged,     // packet carries a non-null vid tag
    input  wire logic [2:0]                   i_vlan_member,    // vlan table bits 18..16
    output logic                              o_fwd_valid,      // decision valid (registered)
    output logic      [2:0]                   o_fwd_ports,      // final egress port mask
    output logic                              o_fwd_drop,       // packet discarded
    output logic                              o_fwd_add_tag,    // double tag to add
    output logic      [11:0]                  o_fwd_tag_vid,    // vid of tag/default vid used
    output logic                              o_fwd_learn,      // learn source address
    output logic      [2:0]                   o_flow_ctrl,      // flow control enable per port
    output logic      [2:0]                   o_backpressure,   // back pressure enable per port
    output logic      [2:0]                   o_tx_en,          // transmit gate per port
    output logic      [2:0]                   o_rx_en           // receive gate per port
);
    import spfc_pkg::*;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] ctrl1_reg [NPORT];
    logic [7:0] ctrl2_reg [NPORT];
    logic [7:0] vidh_reg  [NPORT];
    logic [7:0] vidl_reg  [NPORT];
    logic [7:0] rdata_reg;
    logic       strap_pend_reg;

    // port index of an address, 3 when no port block matches
    function automatic logic [1:0] port_of(input logic [7:0] a);
        unique case (a[7:4])
            4'h1:    port_of = 2'd0;
            4'h2:    port_of = 2'd1;
            4'h3:    port_of = 2'd2;
            default: port_of = 2'd3;
        endcase
    endfunction

    // 12-bit default vid of a port
    function automatic logic [11:0] port_default_vlan_id(input logic [7:0] hi, input logic [7:0] lo);
        port_default_vlan_id = {hi[3:0], lo};
    endfunction

    logic [1:0] wport;
    logic [3:0] wreg;
    assign wport = port_of(i_addr);
    assign wreg  = i_addr[3:0];

    // ------------------------------------------------------------
    // register writes and strap capture
    // ------------------------------------------------------------
    // straps are caught one clock after reset release, since a synchronous
    // reset branch must load constants only; software writes then win afterwards
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            strap_pend_reg <= 1'b1;
            for (int p = 0; p < NPORT; p++) begin
                ctrl1_reg[p] <= C1_RESET_HI | (8'h01 << p);
                ctrl2_reg[p] <= C2_RESET_FIX;
                vidh_reg[p]  <= VIDH_RESET;
                vidl_reg[p]  <= VIDL_RESET;
            end
        end else if (strap_pend_reg) begin
            strap_pend_reg <= 1'b0;
            ctrl1_reg[0][2:1] <= {i_strap_p1_member_of_p3, i_strap_p1_member_of_p2};
            ctrl1_reg[1][2]   <= i_strap_p2_member_of_p3;
            ctrl1_reg[1][0]   <= i_strap_p2_member_of_p1;
            ctrl1_reg[2][1:0] <= {i_strap_p3_member_of_p2, i_strap_p3_member_of_p1};
            ctrl2_reg[0][C2_FORCE_FC] <= i_strap_first_forced_pause;
            ctrl2_reg[1][C2_FORCE_FC] <= i_strap_second_forced_pause;
            for (int p = 0; p < NPORT; p++) begin
                ctrl2_reg[p][C2_BP_EN] <= i_strap_backpressure_on;
            end
        end else if (i_wr && wport != 2'd3) begin
            unique case (wreg)
                4'h1: ctrl1_reg[wport] <= i_wdata & C1_WMASK;
                4'h2: ctrl2_reg[wport] <= i_wdata & C2_WMASK;
                4'h3: vidh_reg[wport]  <= i_wdata;
                4'h4: vidl_reg[wport]  <= i_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    // unmapped addresses read zero
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rdata_reg <= 8'h00;
        end else if (i_rd) begin
            rdata_reg <= 8'h00;
            if (wport != 2'd3) begin
                unique case (wreg)
                    4'h1: rdata_reg <= ctrl1_reg[wport];
                    4'h2: rdata_reg <= ctrl2_reg[wport];
                    4'h3: rdata_reg <= vidh_reg[wport];
                    4'h4: rdata_reg <= vidl_reg[wport];
                    default: rdata_reg <= 8'h00;
                endcase
            end
        end
    end
    assign o_rdata = rdata_reg;

    // ------------------------------------------------------------
    // per-port static controls
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            o_backpressure[p] = ctrl2_reg[p][C2_BP_EN];
            o_tx_en[p]        = ctrl2_reg[p][C2_TX_EN];
            o_rx_en[p]        = ctrl2_reg[p][C2_RX_EN];
        end
        o_flow_ctrl[0] = ctrl2_reg[0][C2_FORCE_FC] | i_an_pause[0];
        o_flow_ctrl[1] = ctrl2_reg[1][C2_FORCE_FC] | i_an_pause[1];
        // port 3 bit has no meaning; the global bit forces it instead
        o_flow_ctrl[2] = i_global_p3_fc | i_an_pause[2];
    end

    // ------------------------------------------------------------
    // forwarding decision, one register stage
    // ------------------------------------------------------------
    logic [1:0]  src;
    logic [7:0]  sc1, sc2;
    logic [11:0] src_port_default_vlan_id;
    logic [2:0]  mirror_ports, sniff_tx, norm_ports, rx_ok, d_ports;
    logic        d_drop;

    assign src      = (i_pkt_src > 2'd2) ? 2'd2 : i_pkt_src;
    assign sc1      = ctrl1_reg[src];
    assign sc2      = ctrl2_reg[src];
    assign src_port_default_vlan_id = port_default_vlan_id(vidh_reg[src], vidl_reg[src]);

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            mirror_ports[p] = ctrl1_reg[p][C1_SNIFFER];
            sniff_tx[p]     = ctrl1_reg[p][C1_TX_SNIFF];
            rx_ok[p]        = ctrl2_reg[p][C2_TX_EN];
        end
        // membership mask limits the normal destinations, never the source itself
        norm_ports = i_pkt_dst & sc1[2:0] & ~(3'b001 << src);
        d_drop = ~sc2[C2_RX_EN]
               | (sc2[C2_ING_FILT] & ~i_vlan_member[src])
               | (sc2[C2_DROP_NPV] & i_pkt_tagged & (i_pkt_vid != src_port_default_vlan_id));
        // mirror copy is added on top of normal forwarding
        d_ports = norm_ports;
        if (sc1[C1_RX_SNIFF] || (|(norm_ports & sniff_tx))) begin
            d_ports = norm_ports | (mirror_ports & ~(3'b001 << src));
        end
        d_ports = d_drop ? 3'b000 : (d_ports & rx_ok);
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_fwd_valid   <= 1'b0;
            o_fwd_ports   <= 3'b000;
            o_fwd_drop    <= 1'b0;
            o_fwd_add_tag <= 1'b0;
            o_fwd_tag_vid <= 12'h000;
            o_fwd_learn   <= 1'b0;
        end else begin
            o_fwd_valid   <= i_pkt_valid;
            o_fwd_ports   <= i_pkt_valid ? d_ports : 3'b000;
            o_fwd_drop    <= i_pkt_valid & d_drop;
            o_fwd_add_tag <= i_pkt_valid & sc1[C1_DBL_TAG];
            o_fwd_tag_vid <= src_port_default_vlan_id;
            o_fwd_learn   <= i_pkt_valid & ~d_drop & ~sc2[C2_LRN_DIS];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_mask_limit;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && !sc1[C1_RX_SNIFF] && !(|(i_pkt_dst & sniff_tx)))
            |=> ((o_fwd_ports & ~$past(sc1[2:0])) == 3'b000);
    endproperty
    a_mask_limit: assert property (p_mask_limit) else $error("forwarded outside mask");

    property p_rx_sniff;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && sc1[C1_RX_SNIFF] && !d_drop)
            |=> ((o_fwd_ports & ($past(mirror_ports & rx_ok) & ~(3'b001 << $past(src)))) ==
                 ($past(mirror_ports & rx_ok) & ~(3'b001 << $past(src))));
    endproperty
    a_rx_sniff: assert property (p_rx_sniff) else $error("mirror copy missing");

    property p_filter;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && sc2[C2_ING_FILT] && !i_vlan_member[src]) |=> o_fwd_drop && o_fwd_ports == 3'b000;
    endproperty
    a_filter: assert property (p_filter) else $error("vlan filter miss");

    property p_npvid;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && sc2[C2_DROP_NPV] && i_pkt_tagged && i_pkt_vid != src_port_default_vlan_id) |=> o_fwd_drop;
    endproperty
    a_npvid: assert property (p_npvid) else $error("non default vid kept");

    property p_learn;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && sc2[C2_LRN_DIS]) |=> !o_fwd_learn;
    endproperty
    a_learn: assert property (p_learn) else $error("learned while disabled");

    property p_dbl_tag;
        @(posedge i_clock) disable iff (i_reset)
        i_pkt_valid |=> (o_fwd_add_tag == $past(sc1[C1_DBL_TAG])) && (o_fwd_tag_vid == $past(src_port_default_vlan_id));
    endproperty
    a_dbl_tag: assert property (p_dbl_tag) else $error("double tag mismatch");

    property p_p3_fc;
        @(posedge i_clock) disable iff (i_reset)
        (!i_global_p3_fc && !i_an_pause[2]) |-> !o_flow_ctrl[2];
    endproperty
    a_p3_fc: assert property (p_p3_fc) else $error("port 3 flow control wrong");

    property p_fc_force;
        @(posedge i_clock) disable iff (i_reset)
        ctrl2_reg[0][C2_FORCE_FC] |-> o_flow_ctrl[0];
    endproperty
    a_fc_force: assert property (p_fc_force) else $error("forced flow control off");

    property p_rd_ctrl2;
        @(posedge i_clock) disable iff (i_reset)
        (i_wr && !strap_pend_reg && i_addr == P2_CTRL2_ADDR) ##1 (i_rd && i_addr == P2_CTRL2_ADDR)
            |=> o_rdata == ($past(i_wdata, 2) & C2_WMASK);
    endproperty
    a_rd_ctrl2: assert property (p_rd_ctrl2) else $error("ctrl2 readback wrong");

    property p_own_bit;
        @(posedge i_clock) disable iff (i_reset)
        $fell(strap_pend_reg) |-> ctrl1_reg[0][0] && ctrl1_reg[1][1] && ctrl1_reg[2][2];
    endproperty
    a_own_bit: assert property (p_own_bit) else $error("own membership bit clear");

    // ------------------------------------------------------------
    // gate and forwarding guards
    // ------------------------------------------------------------

    // a packet never goes back out of its ingress port
    property p_no_src;
        @(posedge i_clock) disable iff (i_reset)
        i_pkt_valid |=> ((o_fwd_ports & (3'b001 << $past(src))) == 3'b000);
    endproperty
    a_no_src: assert property (p_no_src) else $error("sent back to ingress");

    // blocked egress ports get nothing, mirror copies included
    property p_tx_gate;
        @(posedge i_clock) disable iff (i_reset)
        i_pkt_valid |=> ((o_fwd_ports & ~$past(rx_ok)) == 3'b000);
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("blocked port used");

    // a port with reception off drops everything it hears
    property p_rx_gate;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && !sc2[C2_RX_EN]) |=> o_fwd_drop && o_fwd_ports == 3'b000;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx gate ignored");

    // transmit sniff on a destination adds the mirror copy
    property p_tx_sniff;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && !d_drop && |(norm_ports & sniff_tx))
            |=> ((o_fwd_ports & $past(mirror_ports & rx_ok & ~(3'b001 << src))) ==
                 $past(mirror_ports & rx_ok & ~(3'b001 << src)));
    endproperty
    a_tx_sniff: assert property (p_tx_sniff) else $error("tx mirror missing");

    // mirroring adds ports, it never takes normal ones away
    property p_keep_norm;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && !d_drop) |=> ((o_fwd_ports & $past(norm_ports & rx_ok)) == $past(norm_ports & rx_ok));
    endproperty
    a_keep_norm: assert property (p_keep_norm) else $error("normal port lost");

    // a dropped packet goes nowhere and teaches nothing
    property p_drop_quiet;
        @(posedge i_clock) disable iff (i_reset)
        o_fwd_drop |-> (o_fwd_ports == 3'b000) && !o_fwd_learn;
    endproperty
    a_drop_quiet: assert property (p_drop_quiet) else $error("dropped packet leaked");

    // packets that are not dropped learn while the disable bit is clear
    property p_learn_on;
        @(posedge i_clock) disable iff (i_reset)
        (i_pkt_valid && !d_drop && !sc2[C2_LRN_DIS]) |=> o_fwd_learn;
    endproperty
    a_learn_on: assert property (p_learn_on) else $error("learning missing");

    // the global bit alone forces port 3 flow control
    property p_p3_global;
        @(posedge i_clock) disable iff (i_reset)
        i_global_p3_fc |-> o_flow_ctrl[2];
    endproperty
    a_p3_global: assert property (p_p3_global) else $error("port 3 global ignored");

    // the ctrl2 reserved bit can never be written to one
    property p_rsvd_zero;
        @(posedge i_clock) disable iff (i_reset)
        !i_reset |=> !ctrl2_reg[0][C2_RSVD] && !ctrl2_reg[1][C2_RSVD] && !ctrl2_reg[2][C2_RSVD];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

    c_drop:   cover property (@(posedge i_clock) disable iff (i_reset) o_fwd_drop);
    c_mirror: cover property (@(posedge i_clock) disable iff (i_reset)
                              i_pkt_valid && sc1[C1_RX_SNIFF] && |mirror_ports);
    c_wr_rd:  cover property (@(posedge i_clock) disable iff (i_reset) i_wr ##1 i_rd);
    c_tx_snf: cover property (@(posedge i_clock) disable iff (i_reset) i_pkt_valid && |(norm_ports & sniff_tx));
    c_strap:  cover property (@(posedge i_clock) disable iff (i_reset) $fell(strap_pend_reg));
endmodule

//--- design/spfc_pkg.sv
// package: register map, field positions and reset values of the per-port forwarding control bank
package spfc_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          NPORT         = 3;
    // register offsets
    localparam logic [7:0]  P1_CTRL1_ADDR = 8'h11;
    localparam logic [7:0]  P1_CTRL2_ADDR = 8'h12;
    localparam logic [7:0]  P2_CTRL1_ADDR = 8'h21;
    localparam logic [7:0]  P2_CTRL2_ADDR = 8'h22;
    localparam logic [7:0]  P3_CTRL1_ADDR = 8'h31;
    localparam logic [7:0]  P3_CTRL2_ADDR = 8'h32;
    // default tag registers (vid high nibble / vid low byte)
    localparam logic [7:0]  P1_VIDH_ADDR  = 8'h13;
    localparam logic [7:0]  P1_VIDL_ADDR  = 8'h14;
    localparam logic [7:0]  P2_VIDH_ADDR  = 8'h23;
    localparam logic [7:0]  P2_VIDL_ADDR  = 8'h24;
    localparam logic [7:0]  P3_VIDH_ADDR  = 8'h33;
    localparam logic [7:0]  P3_VIDL_ADDR  = 8'h34;
    localparam logic [7:0]  VIDH_RESET    = 8'h00;
    localparam logic [7:0]  VIDL_RESET    = 8'h01;
    // control-one fields
    localparam int          C1_SNIFFER    = 7;
    localparam int          C1_RX_SNIFF   = 6;
    localparam int          C1_TX_SNIFF   = 5;
    localparam int          C1_DBL_TAG    = 4;
    localparam int          C1_RSVD       = 3;
    localparam logic [7:0]  C1_WMASK      = 8'hff;
    localparam logic [7:0]  C1_RESET_HI   = 8'h00;
    // control-two fields
    localparam int          C2_RSVD       = 7;
    localparam int          C2_ING_FILT   = 6;
    localparam int          C2_DROP_NPV   = 5;
    localparam int          C2_FORCE_FC   = 4;
    localparam int          C2_BP_EN      = 3;
    localparam int          C2_TX_EN      = 2;
    localparam int          C2_RX_EN      = 1;
    localparam int          C2_LRN_DIS    = 0;
    localparam logic [7:0]  C2_WMASK      = 8'h7f;
    localparam logic [7:0]  C2_RESET_FIX  = 8'h06;
endpackage

//--- tb/spfc_ctrl_tb.sv
// testbench: register map, strap reset values, port gates and forwarding decisions of the control bank
`timescale 1ns/100ps
module spfc_ctrl_tb;
    import spfc_pkg::*;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic        i_clock = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic        i_pkt_valid = 1'b0, i_pkt_tagged = 1'b0, i_global_p3_fc = 1'b0;
    logic [1:0]  i_pkt_src = 2'h0;
    logic [8:0]  straps = 9'h135;
    logic [2:0]  i_pkt_dst = 3'h0, i_vlan_member = 3'h0, i_an_pause = 3'h0;
    logic [11:0] i_pkt_vid = 12'h000, o_fwd_tag_vid;
    logic        o_fwd_valid, o_fwd_drop, o_fwd_add_tag, o_fwd_learn;
    logic [2:0]  o_fwd_ports, o_flow_ctrl, o_backpressure, o_tx_en, o_rx_en;
    int          failures = 0, checks_done = 0;

    // 10 MHz clock
    always begin
        #50 i_clock = ~i_clock;
    end

    // strap levels 9'h135 mix ones and zeros; a later reset loads the inverse set
    spfc_ctrl spfc_ctrl_i (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_strap_p1_member_of_p3(straps[8]), .i_strap_p1_member_of_p2(straps[7]),
        .i_strap_p2_member_of_p3(straps[6]), .i_strap_p2_member_of_p1(straps[5]),
        .i_strap_p3_member_of_p2(straps[4]), .i_strap_p3_member_of_p1(straps[3]),
        .i_strap_first_forced_pause(straps[2]), .i_strap_second_forced_pause(straps[1]),
        .i_strap_backpressure_on(straps[0]), .i_an_pause(i_an_pause), .i_global_p3_fc(i_global_p3_fc),
        .i_pkt_valid(i_pkt_valid), .i_pkt_src(i_pkt_src), .i_pkt_dst(i_pkt_dst), .i_pkt_vid(i_pkt_vid),
        .i_pkt_tagged(i_pkt_tagged), .i_vlan_member(i_vlan_member), .o_fwd_valid(o_fwd_valid),
        .o_fwd_ports(o_fwd_ports), .o_fwd_drop(o_fwd_drop), .o_fwd_add_tag(o_fwd_add_tag),
        .o_fwd_tag_vid(o_fwd_tag_vid), .o_fwd_learn(o_fwd_learn), .o_flow_ctrl(o_flow_ctrl),
        .o_backpressure(o_backpressure), .o_tx_en(o_tx_en), .o_rx_en(o_rx_en));

    // ----------------------------------------
    // compare, bus and lookup tasks
    // ----------------------------------------
    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_out(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe; returns at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        #1;
    endtask

    // read data are registered at the read edge and hold until the next read, so sample right after it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk_reg($sformatf("reg %h", a), exp, o_rdata);
    endtask

    // learn is judged only for packets that survive, the drop path leaves it open
    task automatic pkt(input logic [2:0] d, input logic [11:0] v, input logic tg, input logic [2:0] m,
                       input logic [2:0] ep, input logic edrop, input logic eadd, input logic elearn);
        @(posedge i_clock);
        i_pkt_valid <= 1'b1; i_pkt_src <= 2'd0; i_pkt_dst <= d;
        i_pkt_vid <= v; i_pkt_tagged <= tg; i_vlan_member <= m;
        @(posedge i_clock);
        i_pkt_valid <= 1'b0;
        #1 chk_out("fwd valid", 12'h1, {11'h0, o_fwd_valid});
        chk_out("fwd ports", {9'h0, ep}, {9'h0, o_fwd_ports});
        chk_out("fwd drop", {11'h0, edrop}, {11'h0, o_fwd_drop});
        chk_out("fwd add tag", {11'h0, eadd}, {11'h0, o_fwd_add_tag});
        if (!edrop) chk_out("fwd learn", {11'h0, elearn}, {11'h0, o_fwd_learn});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_vals;
        rd(P1_CTRL1_ADDR, 8'h05);
        rd(P2_CTRL1_ADDR, 8'h03);
        rd(P3_CTRL1_ADDR, 8'h06);
        rd(P1_CTRL2_ADDR, 8'h1e);
        rd(P2_CTRL2_ADDR, 8'h0e);
        rd(P3_CTRL2_ADDR, 8'h0e);
        rd(P1_VIDH_ADDR, 8'h00);
        rd(P1_VIDL_ADDR, 8'h01);
        chk_out("tx gates", 12'h7, {9'h0, o_tx_en});
        chk_out("rx gates", 12'h7, {9'h0, o_rx_en});
    endtask

    task automatic t_regs;
        wr(P2_CTRL2_ADDR, 8'hff);
        rd(P2_CTRL2_ADDR, 8'h7f);
        wr(P3_CTRL1_ADDR, 8'hff);
        rd(P3_CTRL1_ADDR, 8'hff);
        wr(8'h40, 8'h55);
        rd(8'h40, 8'h00);
        wr(P2_CTRL2_ADDR, 8'h0e);
        wr(P3_CTRL1_ADDR, 8'h06);
    endtask

    task automatic t_gates;
        chk_out("flow ctrl", 12'h1, {9'h0, o_flow_ctrl});
        chk_out("back pressure", 12'h7, {9'h0, o_backpressure});
        @(posedge i_clock);
        i_an_pause <= 3'b010;
        #1 chk_out("flow ctrl an", 12'h3, {9'h0, o_flow_ctrl});
        wr(P3_CTRL2_ADDR, 8'h1e);
        chk_out("flow ctrl p3 bit", 12'h3, {9'h0, o_flow_ctrl});
        @(posedge i_clock);
        i_global_p3_fc <= 1'b1;
        #1 chk_out("flow ctrl p3 global", 12'h7, {9'h0, o_flow_ctrl});
        i_global_p3_fc <= 1'b0;
        wr(P1_CTRL2_ADDR, 8'h06);
        chk_out("flow ctrl cleared", 12'h2, {9'h0, o_flow_ctrl});
        chk_out("back pressure off", 12'h6, {9'h0, o_backpressure});
        wr(P2_CTRL2_ADDR, 8'h0a);
        chk_out("tx gate off", 12'h5, {9'h0, o_tx_en});
        wr(P2_CTRL2_ADDR, 8'h0c);
        chk_out("rx gate off", 12'h5, {9'h0, o_rx_en});
        wr(P2_CTRL2_ADDR, 8'h0e);
        wr(P3_CTRL2_ADDR, 8'h0e);
        i_an_pause <= 3'b000;
    endtask

    task automatic t_fwd;
        pkt(3'b111, 12'h0, 1'b0, 3'b111, 3'b100, 1'b0, 1'b0, 1'b1);
        wr(P1_CTRL1_ADDR, 8'h47);
        wr(P2_CTRL1_ADDR, 8'h83);
        pkt(3'b100, 12'h0, 1'b0, 3'b111, 3'b110, 1'b0, 1'b0, 1'b1);
        wr(P1_CTRL1_ADDR, 8'h07);
        pkt(3'b100, 12'h0, 1'b0, 3'b111, 3'b100, 1'b0, 1'b0, 1'b1);
        wr(P3_CTRL1_ADDR, 8'h26);
        pkt(3'b100, 12'h0, 1'b0, 3'b111, 3'b110, 1'b0, 1'b0, 1'b1);
        wr(P3_CTRL1_ADDR, 8'h06);
        wr(P2_CTRL1_ADDR, 8'h03);
        wr(P1_VIDH_ADDR, 8'h0a);
        wr(P1_VIDL_ADDR, 8'hbc);
        wr(P1_CTRL1_ADDR, 8'h17);
        pkt(3'b100, 12'h005, 1'b1, 3'b111, 3'b100, 1'b0, 1'b1, 1'b1);
        chk_out("tag vid", 12'habc, o_fwd_tag_vid);
        wr(P1_CTRL1_ADDR, 8'h07);
        wr(P1_CTRL2_ADDR, 8'h46);
        pkt(3'b110, 12'h0, 1'b0, 3'b110, 3'b000, 1'b1, 1'b0, 1'b1);
        pkt(3'b110, 12'h0, 1'b0, 3'b001, 3'b110, 1'b0, 1'b0, 1'b1);
        wr(P1_CTRL2_ADDR, 8'h26);
        pkt(3'b010, 12'h123, 1'b1, 3'b111, 3'b000, 1'b1, 1'b0, 1'b1);
        pkt(3'b010, 12'habc, 1'b1, 3'b111, 3'b010, 1'b0, 1'b0, 1'b1);
        wr(P1_CTRL2_ADDR, 8'h07);
        pkt(3'b010, 12'h0, 1'b0, 3'b111, 3'b010, 1'b0, 1'b0, 1'b0);
        wr(P1_CTRL2_ADDR, 8'h04);
        pkt(3'b010, 12'h0, 1'b0, 3'b111, 3'b000, 1'b1, 1'b0, 1'b1);
        wr(P1_CTRL2_ADDR, 8'h06);
        wr(P3_CTRL2_ADDR, 8'h0a);
        pkt(3'b110, 12'h0, 1'b0, 3'b111, 3'b010, 1'b0, 1'b0, 1'b1);
    endtask

    // write then read with no gap between the strobes
    task automatic t_b2b;
        @(posedge i_clock);
        i_wr <= 1'b1; i_addr <= P2_CTRL2_ADDR; i_wdata <= 8'hd5;
        @(posedge i_clock);
        i_wr <= 1'b0; i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk_reg("b2b ctrl2", 8'h55, o_rdata);
    endtask

    // second reset with inverted straps
    task automatic t_restrap;
        @(posedge i_clock);
        i_reset <= 1'b1; straps <= 9'h0ca;
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        #1 chk_out("valid after reset", 12'h0, {11'h0, o_fwd_valid});
        rd(P1_CTRL1_ADDR, 8'h03);
        rd(P2_CTRL1_ADDR, 8'h06);
        rd(P3_CTRL1_ADDR, 8'h05);
        rd(P1_CTRL2_ADDR, 8'h06);
        rd(P2_CTRL2_ADDR, 8'h16);
        rd(P3_CTRL2_ADDR, 8'h06);
    endtask

    // ----------------------------------------
    // verdict and sequencing
    // ----------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // the whole sequence takes about 130 cycles, so 5000 means a hang
    initial begin
        #500000;
        failures++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);  // strap capture edge, no request here
        t_reset_vals();
        t_regs();
        t_gates();
        t_fwd();
        t_b2b();
        t_restrap();
        close_out();
    end
endmodule
